// >>> hw/eba_host.sv
// What this block does
// - At most one row select asserted
// - Words move bit-parallel across a row
// - Low bits to all rows, rows AND-decoded
// - Ready flag set on request, cleared when serviced
// - Cycle shorter than half byte period
// - Guard inactive while counter select changes
`timescale 1ns/1ps
`default_nettype none
module eba_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output var eba_pkg::eba_pins_type pins_q,
    input wire logic [7:0] mem_rdata
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE,
        ST_HOLD
    } eba_state_type;

    logic reg_wr;
    logic [7:0] reg_waddr;
    logic [31:0] reg_wdata;
    logic [3:0] reg_wstrb;
    logic [31:0] rd_data;
    logic [7:0] mem_rdata_s;

    eba_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .reg_wr(reg_wr),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .rd_data(rd_data)
    );

    // Shared read node arrives from outside the clock domain
    eba_sync #(.WIDTH(eba_pkg::WORD_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(mem_rdata),
        .dout(mem_rdata_s)
    );

    // ****************************************************************
    // Operation state
    // ****************************************************************
    eba_state_type state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] op_q, op_d;
    logic [4:0] addr_q, addr_d;
    logic [4:0] op_addr_q, op_addr_d;
    logic [7:0] wbyte_q, wbyte_d;
    logic [7:0] op_data_q, op_data_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic ready_q, ready_d;
    logic refused_q, refused_d;
    eba_pkg::eba_pins_type pins_d;
    logic [eba_pkg::ROWS-1:0] row_dec;
    logic low_wr, cmd_wr, cmd_ok, refuse_now;

    // One row line per combination of the upper address bits
    function automatic logic [3:0] row_onehot(input logic [1:0] upper);
        row_onehot = 4'h1 << upper;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < eba_pkg::ROWS; gi++) begin : g_row
            assign row_dec[gi] = (op_addr_q[4:3] == 2'(gi));
        end
    endgenerate

    always_comb begin
        rd_data = 32'h0;
        if (araddr == eba_pkg::ADDR_OFFSET) begin
            rd_data = {27'h0, addr_q};
        end else if (araddr == eba_pkg::WDATA_OFFSET) begin
            rd_data = {24'h0, wbyte_q};
        end else if (araddr == eba_pkg::STATUS_OFFSET) begin
            rd_data = {30'h0, refused_q, ready_q};
        end else if (araddr == eba_pkg::RDATA_OFFSET) begin
            rd_data = {24'h0, rbyte_q};
        end
    end

    always_comb begin
        low_wr = reg_wr && reg_wstrb[0];
        cmd_wr = low_wr && (reg_waddr == eba_pkg::CMD_OFFSET);
        cmd_ok = cmd_wr && !ready_q && (reg_wdata[1:0] != 2'h3);
        refuse_now = cmd_wr && !cmd_ok;
        state_d = state_q;
        cnt_d = cnt_q + 3'h1;
        op_d = op_q;
        op_addr_d = op_addr_q;
        op_data_d = op_data_q;
        addr_d = addr_q;
        wbyte_d = wbyte_q;
        rbyte_d = rbyte_q;
        ready_d = ready_q;
        refused_d = refused_q;
        if (low_wr && reg_waddr == eba_pkg::ADDR_OFFSET) begin
            addr_d = reg_wdata[4:0];
        end else if (low_wr && reg_waddr == eba_pkg::WDATA_OFFSET) begin
            wbyte_d = reg_wdata[7:0];
        end else if (low_wr && reg_waddr == eba_pkg::STATUS_OFFSET) begin
            if (reg_wdata[eba_pkg::STATUS_REFUSED_BIT]) begin
                refused_d = 1'b0;
            end
        end
        // Set wins over a clear in the same cycle
        if (refuse_now) begin
            refused_d = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                cnt_d = 3'h0;
                if (cmd_ok) begin
                    ready_d = 1'b1;
                    op_d = reg_wdata[1:0];
                    op_addr_d = addr_q;
                    op_data_d = wbyte_q;
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (op_q == eba_pkg::OP_READ) begin
                    if (cnt_q == 3'(eba_pkg::READ_CYC - 1)) begin
                        rbyte_d = mem_rdata_s;
                        ready_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end else if (cnt_q == 3'(eba_pkg::SETUP_CYC - 1)) begin
                    cnt_d = 3'h0;
                    state_d = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_q == 3'(eba_pkg::PULSE_CYC - 1)) begin
                    cnt_d = 3'h0;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_q == 3'(eba_pkg::HOLD_CYC - 1)) begin
                    ready_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_comb begin
        pins_d.row_select_line = '0;
        pins_d.addr = pins_q.addr;
        pins_d.write_enable = 1'b0;
        pins_d.wdata = pins_q.wdata;
        pins_d.count_guard_switch = 1'b0;
        if (state_d != ST_IDLE) begin
            pins_d.row_select_line = row_onehot(op_addr_d[4:3]);
            pins_d.addr = op_addr_d[2:0];
            pins_d.wdata = op_data_d;
        end
        if (state_d == ST_PULSE && op_d == eba_pkg::OP_WRITE) begin
            pins_d.write_enable = 1'b1;
        end
        if (state_d == ST_PULSE && op_d == eba_pkg::OP_COUNT) begin
            pins_d.count_guard_switch = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            op_q <= eba_pkg::OP_WRITE;
            addr_q <= eba_pkg::ADDR_RESET;
            op_addr_q <= eba_pkg::ADDR_RESET;
            wbyte_q <= eba_pkg::WORD_RESET;
            op_data_q <= eba_pkg::WORD_RESET;
            rbyte_q <= eba_pkg::WORD_RESET;
            ready_q <= 1'b0;
            refused_q <= 1'b0;
            pins_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            addr_q <= addr_d;
            op_addr_q <= op_addr_d;
            wbyte_q <= wbyte_d;
            op_data_q <= op_data_d;
            rbyte_q <= rbyte_d;
            ready_q <= ready_d;
            refused_q <= refused_d;
            pins_q <= pins_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    row_onehot_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $onehot0(pins_q.row_select_line))
        else $error("more than one row selected");

    row_decode_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (pins_q.row_select_line != 4'h0) |->
        (pins_q.row_select_line == row_dec))
        else $error("row select does not match upper address");

    low_addr_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (pins_q.row_select_line != 4'h0) |->
        (pins_q.addr == op_addr_q[2:0]))
        else $error("low address differs from operation address");

    write_data_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(pins_q.write_enable) |->
        (pins_q.wdata == op_data_q) && $stable(pins_q.wdata))
        else $error("write word not stable at pulse");

    write_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(pins_q.write_enable) |->
        $stable(pins_q.row_select_line) && (pins_q.row_select_line != 4'h0))
        else $error("select dropped with write enable");

    guard_stable_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pins_q.count_guard_switch |->
        $stable(pins_q.addr) && $stable(pins_q.row_select_line))
        else $error("counter select moved while guard active");

    guard_width_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(pins_q.count_guard_switch) |->
        pins_q.count_guard_switch[*2] ##1
        (!pins_q.count_guard_switch && (pins_q.row_select_line != 4'h0)))
        else $error("guard width or trailing select wrong");

    ready_set_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cmd_ok |=> ready_q ##1 (pins_q.row_select_line != 4'h0))
        else $error("accepted order did not raise ready");

    ready_bound_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(ready_q) |-> ##[5:6] !ready_q)
        else $error("ready not cleared in time");

    refuse_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        refuse_now |=> refused_q && $stable(op_addr_q))
        else $error("busy order not flagged");

    write_cov: cover property (@(posedge aclk) $rose(pins_q.write_enable));
    read_cov: cover property (@(posedge aclk)
        $fell(ready_q) && op_q == eba_pkg::OP_READ);
    count_cov: cover property (@(posedge aclk)
        $rose(pins_q.count_guard_switch));
    refuse_cov: cover property (@(posedge aclk) refuse_now);

endmodule
`default_nettype wire

// >>> hw/eba_pkg.sv
`default_nettype none
package eba_pkg;

    // ****************************************************************
    // Widths and array shape
    // ****************************************************************
    localparam int BUS_ADDR_W = 8;
    localparam int WORD_W = 8;
    localparam int LOW_ADDR_W = 3;
    localparam int ROW_BITS = 2;
    localparam int ROWS = 4;
    localparam int WORD_ADDR_W = LOW_ADDR_W + ROW_BITS;
    localparam int SYNC_STAGES = 2;

    // ****************************************************************
    // Register offsets and fields
    // ****************************************************************
    localparam logic [7:0] CMD_OFFSET = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h04;
    localparam logic [7:0] WDATA_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;
    localparam logic [7:0] RDATA_OFFSET = 8'h10;
    localparam int STATUS_READY_BIT = 0;
    localparam int STATUS_REFUSED_BIT = 1;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_COUNT = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [7:0] WORD_RESET = 8'h00;

    // ****************************************************************
    // Pin timing
    // ****************************************************************
    localparam int CLK_NS = 20;
    localparam int ADDR_SETUP_NS = 45;
    localparam int WE_WIDTH_NS = 30;
    localparam int ADDR_HOLD_NS = 20;
    localparam int READ_ACCESS_NS = 60;
    localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (WE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS
        + SYNC_STAGES;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [ROWS-1:0] row_select_line;
        logic [LOW_ADDR_W-1:0] addr;
        logic write_enable;
        logic [WORD_W-1:0] wdata;
        logic count_guard_switch;
    } eba_pins_type;

    function automatic logic reg_hit(input logic [BUS_ADDR_W-1:0] a);
        reg_hit = (a == CMD_OFFSET) || (a == ADDR_OFFSET) ||
            (a == WDATA_OFFSET) || (a == STATUS_OFFSET) ||
            (a == RDATA_OFFSET);
    endfunction

endpackage
`default_nettype wire

// >>> hw/eba_sync.sv
`timescale 1ns/1ps
`default_nettype none
module eba_sync #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] dout_d;

    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end

endmodule
`default_nettype wire

// >>> hw/eba_axil.sv
`timescale 1ns/1ps
`default_nettype none
module eba_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic reg_wr,
    output logic [7:0] reg_waddr,
    output logic [31:0] reg_wdata,
    output logic [3:0] reg_wstrb,
    input wire logic [31:0] rd_data
);

    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d, reg_wr_d;
    logic [1:0] bresp_d, rresp_d;
    logic [7:0] reg_waddr_d;
    logic [31:0] reg_wdata_d, rdata_d;
    logic [3:0] reg_wstrb_d;

    always_comb begin
        awready_d = awready;
        wready_d = wready;
        bvalid_d = bvalid;
        bresp_d = bresp;
        reg_wr_d = 1'b0;
        reg_waddr_d = reg_waddr;
        reg_wdata_d = reg_wdata;
        reg_wstrb_d = reg_wstrb;
        arready_d = arready;
        rvalid_d = rvalid;
        rdata_d = rdata;
        rresp_d = rresp;
        if (awvalid && awready) begin
            reg_waddr_d = awaddr;
            awready_d = 1'b0;
        end
        if (wvalid && wready) begin
            reg_wdata_d = wdata;
            reg_wstrb_d = wstrb;
            wready_d = 1'b0;
        end
        if (bvalid && bready) begin
            bvalid_d = 1'b0;
        end
        // Both halves held and no response pending
        if (!awready && !wready && !bvalid) begin
            reg_wr_d = 1'b1;
            bvalid_d = 1'b1;
            bresp_d = eba_pkg::reg_hit(reg_waddr) ? eba_pkg::RESP_OKAY :
                eba_pkg::RESP_SLVERR;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        if (arvalid && arready) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = eba_pkg::reg_hit(araddr) ? eba_pkg::RESP_OKAY :
                eba_pkg::RESP_SLVERR;
        end
        if (rvalid && rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= eba_pkg::RESP_OKAY;
            reg_wr <= 1'b0;
            reg_waddr <= '0;
            reg_wdata <= '0;
            reg_wstrb <= '0;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= eba_pkg::RESP_OKAY;
        end else begin
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            reg_wr <= reg_wr_d;
            reg_waddr <= reg_waddr_d;
            reg_wdata <= reg_wdata_d;
            reg_wstrb <= reg_wstrb_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rdata <= rdata_d;
            rresp <= rresp_d;
        end
    end

endmodule
`default_nettype wire

// >>> verif/eba_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eba_mem_model (
    input wire eba_pkg::eba_pins_type pins,
    output logic [7:0] node
);
    logic [7:0] mem [0:31];
    logic [1:0] row;
    logic hit;
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'h00;
        end
    end
    always_comb begin
        row = 2'h0;
        hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (pins.row_select_line[i]) begin
                row = 2'(i);
                hit = 1'b1;
            end
        end
    end
    always @(pins) begin
        if (hit && pins.write_enable) begin
            mem[{row, pins.addr}] = pins.wdata;
        end
    end
    always @(posedge pins.count_guard_switch) begin
        if (hit) begin
            mem[{row, pins.addr}] = mem[{row, pins.addr}] + 8'h01;
        end
    end
    // read keeps data, node pulled up
    assign node = (hit && !pins.write_enable) ? mem[{row, pins.addr}] : 8'hff;
endmodule
`default_nettype wire

// >>> verif/eba_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eba_host_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [3:0] strb = 4'hf;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [7:0] node;
    logic [4:0] exp_addr = 5'h00;
    eba_pkg::eba_pins_type pins;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int pulse_run = 0;

    eba_host uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pins_q(pins), .mem_rdata(node));
    eba_mem_model mdl (.pins(pins), .node(node));

    always #10 aclk = ~aclk;

    // ****
    // Bus tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
        check({30'h0, resp}, {30'h0, r}, "write response");
    endtask

    task automatic rd_only(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r);
        rd_only(a);
        check(rd, e, "read data");
        check({30'h0, resp}, {30'h0, r}, "read response");
    endtask

    task automatic run_op(input logic [1:0] op);
        int n;
        wr(eba_pkg::CMD_OFFSET, {30'h0, op}, eba_pkg::RESP_OKAY);
        n = 0;
        rd = 32'h1;
        while (rd[0] !== 1'b0 && n < 40) begin
            rd_only(eba_pkg::STATUS_OFFSET);
            n++;
        end
        check({31'h0, rd[0]}, 32'h0, "operation done");
    endtask

    task automatic set_word(input logic [4:0] a, input logic [7:0] d);
        exp_addr = a;
        wr(eba_pkg::ADDR_OFFSET, {27'h0, a}, eba_pkg::RESP_OKAY);
        wr(eba_pkg::WDATA_OFFSET, {24'h0, d}, eba_pkg::RESP_OKAY);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        check({15'h0, pins}, 32'h0, "pins idle");
        check({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h1c,
            "bus idle");
        rd_chk(eba_pkg::ADDR_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
        rd_chk(eba_pkg::STATUS_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
        rd_chk(eba_pkg::RDATA_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
    endtask

    task automatic t_rows();
        logic [4:0] a;
        for (int i = 0; i < 4; i++) begin
            a = {2'(i), 3'h5};
            set_word(a, {a, 3'h1} ^ 8'ha5);
            run_op(eba_pkg::OP_WRITE);
            check({24'h0, mdl.mem[a]}, {24'h0, {a, 3'h1} ^ 8'ha5},
                "word");
        end
        for (int i = 0; i < 4; i++) begin
            a = {2'(i), 3'h5};
            set_word(a, 8'h00);
            repeat (2) begin
                run_op(eba_pkg::OP_READ);
                rd_chk(eba_pkg::RDATA_OFFSET, {24'h0, {a, 3'h1} ^ 8'ha5},
                    2'h0);
            end
        end
    endtask

    task automatic t_count();
        set_word(5'h1f, 8'hfe);
        rd_chk(eba_pkg::WDATA_OFFSET, 32'hfe, eba_pkg::RESP_OKAY);
        run_op(eba_pkg::OP_WRITE);
        run_op(eba_pkg::OP_COUNT);
        run_op(eba_pkg::OP_COUNT);
        run_op(eba_pkg::OP_READ);
        rd_chk(eba_pkg::RDATA_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
    endtask

    task automatic t_refuse();
        wr(eba_pkg::CMD_OFFSET, 32'h3, eba_pkg::RESP_OKAY);
        rd_chk(eba_pkg::STATUS_OFFSET, 32'h2, eba_pkg::RESP_OKAY);
        wr(eba_pkg::STATUS_OFFSET, 32'h2, eba_pkg::RESP_OKAY);
        rd_chk(eba_pkg::STATUS_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
        wr(eba_pkg::CMD_OFFSET, 32'h0, eba_pkg::RESP_OKAY);
        run_op(eba_pkg::OP_WRITE);
        rd_chk(eba_pkg::STATUS_OFFSET, 32'h2, eba_pkg::RESP_OKAY);
        wr(8'h14, 32'h1, eba_pkg::RESP_SLVERR);
        rd_chk(8'h14, 32'h0, eba_pkg::RESP_SLVERR);
        strb = 4'h0;
        wr(eba_pkg::ADDR_OFFSET, 32'h3, eba_pkg::RESP_OKAY);
        strb = 4'hf;
        rd_chk(eba_pkg::ADDR_OFFSET, 32'h1f, eba_pkg::RESP_OKAY);
    endtask

    // ****
    // Pin monitor and timeout
    // ****
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    always @(posedge aclk) begin
        check({31'h0, $onehot0(pins.row_select_line)}, 32'h1,
            "rows");
        if (pins.write_enable || pins.count_guard_switch) begin
            pulse_run++;
            check({28'h0, pins.row_select_line}, 32'h1 << exp_addr[4:3],
                "row");
            check({29'h0, pins.addr}, {29'h0, exp_addr[2:0]},
                "low addr");
        end else if (pulse_run != 0) begin
            check(pulse_run, eba_pkg::PULSE_CYC, "pulse width");
            pulse_run = 0;
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_rows();
        t_count();
        t_refuse();
        give_verdict();
    end
endmodule
`default_nettype wire
